/* File: common/wdt_consts.vh */
// offsets, field positions, reset values and counts of the watchdog
// Contract
// - load write changes the count only while the reload write-enable bit is 1
// - 32-bit down counter; interrupt or reset when the count reaches zero
// - control bit 4 starts the counter, counting down from the loaded value
// - control bit 6 set: watchdog reset asserted on the underflow event
// - interrupt mode auto-reloads a count after underflow, only with interrupt enable
// - written reload value reaches the count within 5 counter clock cycles
// - interrupt and readable count lag the counter by at most 2 bus clocks
// - control bit 3 clear: bus clock; set: one of 3 external sources
// - 3-bit prescale field divides the source clock, at most by 256
// - load-to-flag time is load times prescaled period plus small sync slack
// - after reset the timeout is 2000 ms with no software setup
// - count register reads the live counter, reset value 0x0000FFFF
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

`define OFS_RELOAD          12'h000
`define OFS_COUNT           12'h004
`define OFS_CONTROL         12'h008
`define OFS_STATUS          12'h00C
`define OFS_MASK            12'h010

`define RST_RELOAD          32'h0000_0000
`define RST_COUNT           32'h0000_FFFF
`define RST_CONTROL         32'h0000_805C
`define RST_MASK            3'h1
`define CTL_WRITE_MASK      32'h0000_807F

`define CTL_PRESCALE_LSB    0
`define CTL_PRESCALE_MSB    2
`define CTL_EXT_CLK         3
`define CTL_COUNT_EN        4
`define CTL_IRQ_EN          5
`define CTL_RST_EN          6
`define CTL_LOAD_WEN        15

`define ST_UNDERFLOW        0
`define ST_RESET_EVT        1
`define ST_LOAD_BLOCKED     2
`define ST_WIDTH            3

`define RESET_PULSE_CYCLES  5'h10
`define HSIZE_WORD          3'h2

`endif

/* File: logic/counter_tick_gen.v */
// clock source select and power-of-two prescaler for the watchdog counter
`default_nettype none
`include "wdt_consts.vh"
module counter_tick_gen (
  // clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // source selection
  input  wire [2:0] ext_clk_pin,
  input  wire [1:0] ext_source_select,
  input  wire       external_clock_select,
  input  wire       clock_enable_in,
  input  wire [2:0] prescale_select,
  // one-cycle tick of the prescaled counter clock
  output reg        counter_tick
);
  reg  [2:0] sync1_reg;
  reg  [2:0] sync2_reg;
  reg  [2:0] sync3_reg;
  reg  [7:0] div_reg;
  wire [2:0] rise;
  wire       src_tick;
  wire [8:0] div_mask;

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_sync
      // pins are asynchronous: two flops before any edge logic
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_reg[i] <= 1'b0;
          sync2_reg[i] <= 1'b0;
          sync3_reg[i] <= 1'b0;
        end else begin
          sync1_reg[i] <= ext_clk_pin[i];
          sync2_reg[i] <= sync1_reg[i];
          sync3_reg[i] <= sync2_reg[i];
        end
      end
      assign rise[i] = sync2_reg[i] & ~sync3_reg[i];
    end
  endgenerate

  // source 3 unused: selection code 3 yields no ticks
  assign src_tick = !clock_enable_in ? 1'b0 :
                    !external_clock_select ? 1'b1 :
                    (ext_source_select == 2'h3) ? 1'b0 :
                    rise[ext_source_select];

  // division 2^(n+1): n = 7 gives 256
  assign div_mask = (9'h002 << prescale_select) - 9'h001;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg      <= 8'h00;
      counter_tick <= 1'b0;
    end else begin
      if (src_tick) begin
        div_reg <= div_reg + 8'h01;
      end
      // first period after a prescale change may be short
      counter_tick <= src_tick & ((div_reg & div_mask[7:0]) == div_mask[7:0]);
    end
  end
endmodule
`default_nettype wire

/* File: logic/ahb_reg_port.v */
// ahb-lite slave front end: address phase capture and registered read data
`default_nettype none
`include "wdt_consts.vh"
module ahb_reg_port (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  // register file side
  output wire [11:0] rd_addr,
  input  wire [31:0] rd_value,
  output wire        wr_strobe,
  output wire [11:0] wr_addr
);
  reg  [31:0] hrdata_reg;
  reg         wr_pending_reg;
  reg  [11:0] wr_addr_reg;
  wire        take;

  // never stalls, never errors
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign take      = hsel & hready & htrans[1];
  assign rd_addr   = {haddr[11:2], 2'b00};
  assign hrdata    = hrdata_reg;
  assign wr_strobe = wr_pending_reg;
  assign wr_addr   = wr_addr_reg;

  // read data snapshot at the address edge, so data phase is zero-wait
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg     <= 32'h0000_0000;
      wr_pending_reg <= 1'b0;
      wr_addr_reg    <= 12'h000;
    end else begin
      wr_pending_reg <= take & hwrite & (hsize == `HSIZE_WORD);
      if (take) begin
        wr_addr_reg <= rd_addr;
      end
      if (take & !hwrite) begin
        hrdata_reg <= rd_value;
      end
    end
  end
endmodule
`default_nettype wire

/* File: logic/watchdog_down_counter.v */
// watchdog down counter with ahb-lite registers, interrupt and reset output
`default_nettype none
`include "wdt_consts.vh"
module watchdog_down_counter (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // external clock pins and clock unit controls
  input  wire [2:0]  ext_clk_pin,
  input  wire [1:0]  ext_source_select,
  input  wire        wdt_clock_enable,
  // event outputs
  output wire        watchdog_irq,
  output wire        watchdog_reset_out
);

  // bus front end
  wire [11:0] rd_addr;
  wire [11:0] wr_addr;
  wire        wr_strobe;
  reg  [31:0] rd_value;

  // register state
  reg  [31:0]          reload_value_reg;
  reg  [31:0]          count_reg;
  reg  [31:0]          count_next;
  reg  [31:0]          control_reg;
  reg  [`ST_WIDTH-1:0] status_reg;
  reg  [`ST_WIDTH-1:0] status_next;
  reg  [`ST_WIDTH-1:0] mask_reg;
  reg                  armed_reg;
  reg                  armed_next;
  reg                  irq_reg;
  reg                  reset_out_reg;
  reg  [4:0]           reset_hold_reg;

  // decoded writes
  wire wr_reload;
  wire wr_control;
  wire wr_status;
  wire wr_mask;

  // control fields
  wire       count_enable;
  wire       underflow_irq_enable;
  wire       underflow_reset_enable;
  wire       reload_write_enable;
  wire       external_clock_select;
  wire [2:0] prescale_select;

  // counter events
  wire counter_tick;
  wire run_tick;
  wire underflow;
  wire load_taken;
  wire load_blocked;
  wire irq_event;
  wire reset_event;

  ahb_reg_port u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_addr   (rd_addr),
    .rd_value  (rd_value),
    .wr_strobe (wr_strobe),
    .wr_addr   (wr_addr)
  );

  counter_tick_gen u_tick (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .ext_clk_pin           (ext_clk_pin),
    .ext_source_select     (ext_source_select),
    .external_clock_select (external_clock_select),
    .clock_enable_in       (wdt_clock_enable),
    .prescale_select       (prescale_select),
    .counter_tick          (counter_tick)
  );

  assign wr_reload  = wr_strobe & (wr_addr == `OFS_RELOAD);
  assign wr_control = wr_strobe & (wr_addr == `OFS_CONTROL);
  assign wr_status  = wr_strobe & (wr_addr == `OFS_STATUS);
  assign wr_mask    = wr_strobe & (wr_addr == `OFS_MASK);

  assign count_enable           = control_reg[`CTL_COUNT_EN];
  assign underflow_irq_enable   = control_reg[`CTL_IRQ_EN];
  assign underflow_reset_enable = control_reg[`CTL_RST_EN];
  assign reload_write_enable    = control_reg[`CTL_LOAD_WEN];
  assign external_clock_select  = control_reg[`CTL_EXT_CLK];
  assign prescale_select        = control_reg[`CTL_PRESCALE_MSB:`CTL_PRESCALE_LSB];

  // count only on ticks of the prescaled clock while enabled
  assign run_tick = counter_tick & count_enable;

  // reaching zero from a loaded value; armed stops a stuck zero re-firing
  // a taken load in the same cycle suppresses the underflow: software restart wins
  assign underflow = run_tick & armed_reg & ~load_taken &
                     (count_reg <= 32'h0000_0001);

  assign load_taken   = wr_reload & reload_write_enable;
  assign load_blocked = wr_reload & ~reload_write_enable;

  // interrupt flag only in interrupt mode
  assign irq_event   = underflow & underflow_irq_enable;
  assign reset_event = underflow & underflow_reset_enable;

  // reload value store; kept even when the count is locked
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_value_reg <= `RST_RELOAD;
    end else if (wr_reload) begin
      reload_value_reg <= hwdata;
    end
  end

  // control register; unused bits read zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_reg <= `RST_CONTROL;
    end else if (wr_control) begin
      control_reg <= hwdata & `CTL_WRITE_MASK;
    end
  end

  // interrupt mask, same layout as status
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_reg <= `RST_MASK;
    end else if (wr_mask) begin
      mask_reg <= hwdata[`ST_WIDTH-1:0];
    end
  end

  // down counter next state
  always @* begin
    count_next = count_reg;
    armed_next = armed_reg;
    if (load_taken) begin
      // load wins over a same-cycle tick: software restart takes priority
      count_next = hwdata;
      armed_next = 1'b1;
    end else if (underflow) begin
      if (underflow_irq_enable) begin
        // stay armed so the next period can fire again
        count_next = reload_value_reg;
        armed_next = 1'b1;
      end else begin
        count_next = 32'h0000_0000;
        armed_next = 1'b0;
      end
    end else if (run_tick && (count_reg != 32'h0000_0000)) begin
      count_next = count_reg - 32'h0000_0001;
    end
  end

  // the reset value gives the default timeout without software
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= `RST_COUNT;
      armed_reg <= 1'b1;
    end else begin
      count_reg <= count_next;
      armed_reg <= armed_next;
    end
  end

  // sticky status, write one to clear; a new event wins over its clear
  always @* begin
    status_next = status_reg;
    if (wr_status) begin
      status_next = status_reg & ~hwdata[`ST_WIDTH-1:0];
    end
    if (load_taken) begin
      // a reload acknowledges a pending underflow request
      status_next[`ST_UNDERFLOW] = 1'b0;
    end
    if (irq_event) begin
      status_next[`ST_UNDERFLOW] = 1'b1;
    end
    if (reset_event) begin
      status_next[`ST_RESET_EVT] = 1'b1;
    end
    if (load_blocked) begin
      status_next[`ST_LOAD_BLOCKED] = 1'b1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= {`ST_WIDTH{1'b0}};
    end else begin
      status_reg <= status_next;
    end
  end

  // registered level interrupt: taken from status_next, so it changes on the same bus clock edge as the status bit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_next & mask_reg);
    end
  end

  assign watchdog_irq = irq_reg;

  // reset pulse of fixed length so the system reset logic can catch it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_hold_reg <= 5'h00;
      reset_out_reg  <= 1'b0;
    end else if (reset_event) begin
      reset_hold_reg <= `RESET_PULSE_CYCLES - 5'h01;
      reset_out_reg  <= 1'b1;
    end else if (reset_hold_reg != 5'h00) begin
      reset_hold_reg <= reset_hold_reg - 5'h01;
      reset_out_reg  <= 1'b1;
    end else begin
      reset_out_reg  <= 1'b0;
    end
  end

  assign watchdog_reset_out = reset_out_reg;

  // read mux; load register is write-only and reads zero
  always @* begin
    case (rd_addr)
      `OFS_RELOAD: begin
        rd_value = 32'h0000_0000;
      end
      `OFS_COUNT: begin
        rd_value = count_reg;
      end
      `OFS_CONTROL: begin
        rd_value = control_reg;
      end
      `OFS_STATUS: begin
        rd_value = {{(32-`ST_WIDTH){1'b0}}, status_reg};
      end
      `OFS_MASK: begin
        rd_value = {{(32-`ST_WIDTH){1'b0}}, mask_reg};
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

endmodule
`default_nettype wire

/* File: tb/watchdog_down_counter_properties.sv */
// port checker for the watchdog down counter
`default_nettype none
module wdt_port_checker (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // events
  input wire logic        wdt_clock_enable,
  input wire logic        watchdog_irq,
  input wire logic        watchdog_reset_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire take = hsel && hready && htrans[1];
  wire rd   = take && !hwrite;
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus not ready");
  property p_rd_stand; !rd |=> $stable(hrdata); endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
  property p_rd_reload; rd && haddr[11:0] == 12'h000 |=> hrdata == 32'h0000_0000; endproperty
  a_rd_reload: assert property (p_rd_reload) else $error("reload not zero");
  property p_rd_ctl;
    rd && haddr[11:0] == 12'h008 |=> hrdata[31:16] == 16'h0000 && hrdata[14:7] == 8'h00;
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("spare bits set");
  property p_rst_pulse; $rose(watchdog_reset_out) |-> watchdog_reset_out[*8]; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse short");
  property p_rst_len;
    $fell(watchdog_reset_out) |-> $past(watchdog_reset_out, 16) && !$past(watchdog_reset_out, 17);
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length");
  property p_no_tick; !wdt_clock_enable [*8] |=> !$rose(watchdog_reset_out); endproperty
  a_no_tick: assert property (p_no_tick) else $error("reset with clock off");
  property p_irq_fall; $fell(watchdog_irq) |-> $past(take && hwrite, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
endmodule
bind watchdog_down_counter wdt_port_checker chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .wdt_clock_enable(wdt_clock_enable), .watchdog_irq(watchdog_irq),
  .watchdog_reset_out(watchdog_reset_out)
);
`default_nettype wire

/* File: tb/watchdog_down_counter_tb.sv */
// self-checking bench for the watchdog down counter
`default_nettype none
module watchdog_down_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0;
  logic        hresetn = 0;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic        clk_en = 1;
  logic        ext_run = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [2:0]  ext_pin = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] seed = 32'h0000_0045;
  logic [31:0] v;
  logic [31:0] v0;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  wire         irq;
  wire         rst_out;
  int          fail_count = 0;
  int          checked = 0;
  int          rst_cyc = 0;
  int          ediv = 0;
  int          c;
  int          ld;

  always #4 hclk = ~hclk;
  // pin 0 is a slow source clock, the others noise
  always @(posedge hclk) begin
    rst_cyc <= rst_cyc + int'(rst_out === 1'b1);
    ediv <= (ediv == 4) ? 0 : ediv + 1;
    ext_pin <= {seed[2:1], ext_pin[0] ^ (ext_run && ediv == 4)};
  end

  watchdog_down_counter DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .ext_clk_pin(ext_pin), .ext_source_select(2'h0),
    .wdt_clock_enable(clk_en), .watchdog_irq(irq), .watchdog_reset_out(rst_out)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1, a, d, x);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // counts edges after the call until the chosen output is high
  task automatic wait_sig(input bit s, input int lim, output int n);
    n = 0;
    @(negedge hclk);
    while ((s ? rst_out : irq) !== 1'b1 && n < lim) begin
      @(negedge hclk);
      n++;
    end
  endtask

  task automatic finish_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    bus(0, 12'h004, 0, v);
    chk(v, 32'h0000_ffff);
    bus(0, 12'h008, 0, v);
    chk(v, 32'h0000_805c);
    bus(0, 12'h010, 0, v);
    chk(v, 32'h0000_0001);
    bus(0, 12'h020, 0, v);
    chk(v, 32'h0000_0000);
    // every prescale step, bus clock source, interrupt mode
    for (int n = 0; n < 8; n++) begin
      ld = 2 + int'(rnd() % 4);
      wr(12'h008, 32'h0000_8030 | n);
      wr(12'h000, ld);
      wait_sig(0, 3000, c);
      chk_rng(c, (ld - 1) * (2 << n), ld * (2 << n) + 4);
      bus(0, 12'h00c, 0, v);
      chk(v, 32'h0000_0001);
      bus(0, 12'h004, 0, v);
      chk_rng(v, 1, ld);
    end
    // blocked load, masking and clear
    wr(12'h008, 32'h0000_0020);
    bus(0, 12'h004, 0, v0);
    ld = rnd();
    wr(12'h000, ld);
    bus(0, 12'h004, 0, v);
    chk(v, v0);
    wr(12'h00c, 32'h0000_0001);
    bus(0, 12'h00c, 0, v);
    chk(v, 32'h0000_0004);
    wait_sig(0, 3, c);
    chk(c, 3);
    wr(12'h010, 32'h0000_0004);
    wait_sig(0, 3, c);
    chk(c, 1);
    wr(12'h00c, 32'h0000_0004);
    repeat (2) @(negedge hclk);
    chk(irq, 0);
    wr(12'h008, 32'h0000_8020);
    wr(12'h000, ld);
    bus(0, 12'h004, 0, v);
    chk(v, ld);
    // kicks hold off the reset, then it fires
    wr(12'h008, 32'h0000_8050);
    repeat (6) wr(12'h000, 32'h0000_000c);
    chk(rst_cyc, 0);
    wait_sig(1, 100, c);
    chk_rng(c, 22, 28);
    ld = rst_cyc;
    repeat (20) @(negedge hclk);
    chk(rst_cyc - ld, 16);
    chk(irq, 0);
    bus(0, 12'h004, 0, v);
    chk(v, 0);
    bus(0, 12'h00c, 0, v);
    chk(v, 32'h0000_0002);
    // external source, then clock unit gate off
    wr(12'h010, 32'h0000_0001);
    wr(12'h008, 32'h0000_8038);
    ext_run <= 1;
    wr(12'h000, 32'h0000_0003);
    wait_sig(0, 300, c);
    chk_rng(c, 40, 114);
    clk_en <= 0;
    wr(12'h000, 32'h0000_0003);
    wait_sig(0, 200, c);
    chk(c, 200);
    finish_test();
  end
endmodule
`default_nettype wire
